// [cfm_core.sv]
// Purpose: flag generation, interrupt mask, low-power and break sequencing
// Assumes: inputs synchronous to mclk; operands fetched outside
// Notes:   stacked bytes other than flags are supplied by the memory side
`timescale 1ns/1ps
module cfm_core #(
   parameter int          NIRQ        = 4,
   parameter int          STAB_CYCLES = 4096,
   parameter logic [7:0]  OP_DECADJ   = 8'h72,
   parameter logic [7:0]  OP_CLRMASK  = 8'h9a,
   parameter logic [7:0]  OP_RETI     = 8'h80,
   parameter logic [7:0]  OP_SWINT    = 8'h83,
   parameter logic [7:0]  OP_WAIT     = 8'h8f,
   parameter logic [7:0]  OP_STOP     = 8'h8e
) (
   input  wire logic             mclk,
   input  wire logic             rst,
   input  wire logic             execStart,
   input  wire logic [15:0]      opcode,
   input  wire logic [7:0]       operand,
   input  wire logic [7:0]       accIn,
   input  wire logic [NIRQ-1:0]  irqReq,
   input  wire logic             breakReq,
   input  wire logic             monitorMode,
   input  wire logic [1:0]       regAddr,
   input  wire logic [7:0]       regWrData,
   input  wire logic             regWr,
   input  wire logic             regRd,
   output logic [7:0]            regRdData,
   output logic                  ready,
   output logic                  done,
   output logic [7:0]            result,
   output logic [7:0]            condition_flags,
   output logic [15:0]           stack_pointer,
   output logic [15:0]           indexReg,
   output logic                  pushStrobe,
   output logic [2:0]            pushSel,
   output logic                  vectorFetch,
   output logic [15:0]           vectorAddr,
   output logic [NIRQ-1:0]       irqAck,
   output logic [7:0]            instrReg,
   output logic                  coreClockRun,
   output logic                  breakActive
);
   cfm_pkg::cfm_state_e state;
   logic [3:0]      cnt;
   logic [12:0]     stabCnt;
   logic [15:0]     pendOp;
   logic [7:0]      pendOpnd;
   logic [7:0]      pendRes;
   logic [7:0]      pendFlags;
   logic [NIRQ-1:0] svcAck;
   logic [15:0]     svcVec;

   // ***************************************
   // decode
   // ***************************************
   wire       isPre   = opcode[15:8] == cfm_pkg::OP_PREFIX;
   wire [3:0] hi      = opcode[7:4];
   wire [3:0] lo      = opcode[3:0];
   wire       aluPage = isPre ? (hi == 4'he || hi == 4'hd) : (hi >= 4'ha);
   wire       shPage  = isPre ? (hi == 4'h6) : (hi >= 4'h3 && hi <= 4'h7);
   wire       isAdc   = aluPage && lo == cfm_pkg::LO_ADC;
   wire       isAdd   = aluPage && lo == cfm_pkg::LO_ADD;
   wire       isAnd   = aluPage && lo == cfm_pkg::LO_AND;
   wire       isShl   = shPage && lo == cfm_pkg::LO_SHL;
   wire       isShr   = shPage && lo == cfm_pkg::LO_SHR;
   wire       isDecAdj = !isPre && opcode[7:0] == OP_DECADJ;
   wire       isAluOp = isAdc || isAdd || isAnd || isShl || isShr || isDecAdj;

   // table cycle counts per addressing mode
   function automatic logic [3:0] cycFor(input logic [15:0] op);
      logic [3:0] h;
      h = op[7:4];
      cycFor = 4'h1;
      if (op[15:8] == cfm_pkg::OP_PREFIX)
         cycFor = (h == 4'hd) ? 4'h5 : (h == 4'he && op[3:0] != 4'h7
                  && op[3:0] != 4'h8) ? 4'h4 : (h == 4'h6) ? 4'h5 : 4'h1;
      else if (op[7:0] == cfm_pkg::OP_SPADD || op[7:0] == cfm_pkg::OP_IXADD)
         cycFor = 4'h2;
      else if (h >= 4'ha)
         cycFor = (h == 4'ha || h == 4'hf) ? 4'h2 : (h == 4'hb || h == 4'he)
                  ? 4'h3 : 4'h4;
      else if (h >= 4'h3 && h <= 4'h7)
         cycFor = (h == 4'h3 || h == 4'h6) ? 4'h4 : (h == 4'h7) ? 4'h3 : 4'h1;
      else if (op[7:0] == OP_DECADJ)
         cycFor = 4'h2;
   endfunction

   // ***************************************
   // arithmetic and flags
   // ***************************************
   wire       cin    = isAdc && condition_flags[cfm_pkg::FL_C];
   wire [8:0] sum9   = {1'b0, accIn} + {1'b0, operand} + {8'h00, cin};
   wire [4:0] half5  = {1'b0, accIn[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
   wire       lowFix = condition_flags[cfm_pkg::FL_H] || accIn[3:0] > 4'h9;
   wire       hiFix  = condition_flags[cfm_pkg::FL_C] || accIn > 8'h99 ||
                       (accIn > 8'h89 && accIn[3:0] > 4'h9);
   wire [7:0] daaCor = {hiFix ? 4'h6 : 4'h0, lowFix ? 4'h6 : 4'h0};
   wire [8:0] daa9   = {1'b0, accIn} + {1'b0, daaCor};
   wire [7:0] shl    = {operand[6:0], 1'b0};
   wire [7:0] shr    = {operand[7], operand[7:1]};
   wire [7:0] aluRes = (isAdc || isAdd) ? sum9[7:0] : isAnd ? (accIn & operand) :
                       isShl ? shl : isShr ? shr : isDecAdj ? daa9[7:0] : accIn;
   wire       addV   = (accIn[7] == operand[7]) && (sum9[7] != accIn[7]);
   wire       nFlag  = aluRes[7];
   wire       zFlag  = aluRes == 8'h00;
   wire       cFlag  = (isAdc || isAdd) ? sum9[8] : isShl ? operand[7] :
                       isShr ? operand[0] : isDecAdj ? (hiFix || daa9[8]) :
                       condition_flags[cfm_pkg::FL_C];
   wire       vFlag  = (isAdc || isAdd) ? addV : isAnd ? 1'b0 :
                       (isShl || isShr) ? (nFlag ^ cFlag) :
                       condition_flags[cfm_pkg::FL_V];
   wire       hFlag  = (isAdc || isAdd) ? half5[4] : condition_flags[cfm_pkg::FL_H];
   wire [7:0] aluFlags = {vFlag, 2'b11, hFlag, condition_flags[cfm_pkg::FL_I],
                          nFlag, zFlag, cFlag};

   // ***************************************
   // interrupt selection
   // ***************************************
   function automatic logic [NIRQ-1:0] pickFirst(input logic [NIRQ-1:0] req);
      pickFirst = '0;
      for (int k = NIRQ - 1; k >= 0; k--) begin
         if (req[k]) begin
            pickFirst = '0;
            pickFirst[k] = 1'b1;
         end
      end
   endfunction

   wire [NIRQ-1:0] irqPick = pickFirst(irqReq);
   logic [15:0] irqVec;
   always_comb begin
      irqVec = cfm_pkg::VEC_IRQ_TOP;
      for (int k = NIRQ - 1; k >= 0; k--) begin
         if (irqReq[k])
            irqVec = cfm_pkg::VEC_IRQ_TOP - 16'(2 * (k + 1));
      end
   end
   wire irqTake = |irqReq && !condition_flags[cfm_pkg::FL_I];
   wire brkTake = breakReq && !breakActive;
   wire accept  = state == cfm_pkg::ST_IDLE && execStart && ready;
   wire commit  = state == cfm_pkg::ST_EXEC && cnt == 4'h0;
   wire [7:0] opLo   = pendOp[7:0];
   wire       pendPre = pendOp[15:8] == cfm_pkg::OP_PREFIX;
   wire [15:0] sext  = {{8{pendOpnd[7]}}, pendOpnd};
   wire       stabDone = stabCnt == 13'(STAB_CYCLES - 1);

   // ***************************************
   // sequencer
   // ***************************************
   always_ff @(posedge mclk) begin
      if (rst) begin
         state        <= cfm_pkg::ST_IDLE;
         cnt          <= 4'h0;
         stabCnt      <= 13'h0000;
         condition_flags <= cfm_pkg::FLAGS_RST;
         stack_pointer <= cfm_pkg::STACK_RST;
         indexReg     <= 16'h0000;
         pendOp       <= 16'h0000;
         pendOpnd     <= 8'h00;
         pendRes      <= 8'h00;
         pendFlags    <= cfm_pkg::FLAGS_RST;
         result       <= 8'h00;
         ready        <= 1'b0;
         done         <= 1'b0;
         pushStrobe   <= 1'b0;
         pushSel      <= 3'h0;
         vectorFetch  <= 1'b0;
         vectorAddr   <= 16'h0000;
         irqAck       <= '0;
         svcAck       <= '0;
         svcVec       <= 16'h0000;
         instrReg     <= 8'h00;
         coreClockRun <= 1'b1;
         breakActive  <= 1'b0;
      end else begin
         done        <= 1'b0;
         vectorFetch <= 1'b0;
         irqAck      <= '0;
         pushStrobe  <= 1'b0;
         if (regWr && regAddr == cfm_pkg::OFS_FLAGS)
            condition_flags <= regWrData | cfm_pkg::FLAGS_FIXED |
               (condition_flags & 8'h08);
         unique case (state)
            cfm_pkg::ST_IDLE: begin
               if (accept) begin
                  state     <= cfm_pkg::ST_EXEC;
                  ready     <= 1'b0;
                  cnt       <= cycFor(opcode) - 4'h1;
                  pendOp    <= opcode;
                  pendOpnd  <= operand;
                  pendRes   <= aluRes;
                  pendFlags <= isAluOp ? aluFlags : condition_flags;
               end else if (brkTake) begin
                  instrReg    <= OP_SWINT;
                  breakActive <= 1'b1;
                  svcAck      <= '0;
                  svcVec      <= monitorMode ? cfm_pkg::VEC_BRK_MON
                                             : cfm_pkg::VEC_BRK;
                  state       <= cfm_pkg::ST_PUSH;
                  pushSel     <= 3'h0;
                  pushStrobe  <= 1'b1;
                  ready       <= 1'b0;
               end else if (irqTake) begin
                  svcAck     <= irqPick;
                  svcVec     <= irqVec;
                  state      <= cfm_pkg::ST_PUSH;
                  pushSel    <= 3'h0;
                  pushStrobe <= 1'b1;
                  ready      <= 1'b0;
               end else begin
                  ready <= 1'b1;
               end
            end
            cfm_pkg::ST_EXEC: begin
               cnt <= cnt - 4'h1;
               if (commit) begin
                  done            <= 1'b1;
                  result          <= pendRes;
                  condition_flags <= pendFlags | cfm_pkg::FLAGS_FIXED;
                  state           <= cfm_pkg::ST_IDLE;
                  if (!pendPre && opLo == cfm_pkg::OP_SPADD)
                     stack_pointer <= stack_pointer + sext;
                  if (!pendPre && opLo == cfm_pkg::OP_IXADD)
                     indexReg <= indexReg + sext;
                  if (!pendPre && opLo == OP_CLRMASK)
                     condition_flags[cfm_pkg::FL_I] <= 1'b0;
                  if (!pendPre && opLo == OP_RETI) begin
                     condition_flags <= pendOpnd | cfm_pkg::FLAGS_FIXED;
                     if (!breakReq)
                        breakActive <= 1'b0;
                  end
                  if (!pendPre && opLo == OP_SWINT) begin
                     svcAck     <= '0;
                     svcVec     <= cfm_pkg::VEC_BRK;
                     state      <= cfm_pkg::ST_PUSH;
                     pushSel    <= 3'h0;
                     pushStrobe <= 1'b1;
                  end
                  if (!pendPre && (opLo == OP_WAIT || opLo == OP_STOP)) begin
                     condition_flags[cfm_pkg::FL_I] <= 1'b0;
                     coreClockRun <= 1'b0;
                     state <= (opLo == OP_WAIT) ? cfm_pkg::ST_WAIT
                                                : cfm_pkg::ST_STOP;
                  end
               end
            end
            cfm_pkg::ST_PUSH: begin
               // pcl, pch, x, a, flags; index high is left to software
               if (pushSel == cfm_pkg::PUSH_LAST) begin
                  condition_flags[cfm_pkg::FL_I] <= 1'b1;
                  state <= cfm_pkg::ST_VECT;
               end else begin
                  pushSel    <= pushSel + 3'h1;
                  pushStrobe <= 1'b1;
               end
            end
            cfm_pkg::ST_VECT: begin
               vectorFetch <= 1'b1;
               vectorAddr  <= svcVec;
               irqAck      <= svcAck;
               state       <= cfm_pkg::ST_IDLE;
            end
            cfm_pkg::ST_WAIT: begin
               if (|irqReq) begin
                  coreClockRun <= 1'b1;
                  state        <= cfm_pkg::ST_IDLE;
               end
            end
            cfm_pkg::ST_STOP: begin
               stabCnt <= 13'h0000;
               if (irqReq[0])
                  state <= cfm_pkg::ST_STAB;
            end
            cfm_pkg::ST_STAB: begin
               stabCnt <= stabCnt + 13'h0001;
               if (stabDone) begin
                  coreClockRun <= 1'b1;
                  state        <= cfm_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // ***************************************
   // register port
   // ***************************************
   wire inLowPower = state == cfm_pkg::ST_WAIT || state == cfm_pkg::ST_STOP ||
                     state == cfm_pkg::ST_STAB;
   wire [7:0] statusByte = {5'h00, inLowPower, breakActive, ready};
   wire [7:0] rdMux = (regAddr == cfm_pkg::OFS_FLAGS) ? condition_flags :
                      (regAddr == cfm_pkg::OFS_STATUS) ? statusByte : 8'h00;

   always_ff @(posedge mclk) begin
      if (rst)
         regRdData <= 8'h00;
      else
         regRdData <= regRd ? rdMux : 8'h00;
   end

   // ***************************************
   // checks
   // ***************************************
   logic [12:0] stopGap;
   always_ff @(posedge mclk) begin
      if (rst || state != cfm_pkg::ST_STAB)
         stopGap <= 13'h0000;
      else
         stopGap <= stopGap + 13'h0001;
   end

   reset_mask_set_a: assert property (@(posedge mclk)
      rst |=> condition_flags[cfm_pkg::FL_I]) else $error("mask not set by reset");
   fixed_bits_a: assert property (@(posedge mclk) disable iff (rst)
      condition_flags[6:5] == 2'b11) else $error("flag bits 6 5 not one");
   masked_block_a: assert property (@(posedge mclk) disable iff (rst)
      (state == cfm_pkg::ST_IDLE && !accept && !brkTake &&
       condition_flags[cfm_pkg::FL_I]) |=> !pushStrobe)
      else $error("masked interrupt taken");
   push_five_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(pushStrobe) |-> pushStrobe[*5] ##1 !pushStrobe)
      else $error("stacking not five bytes");
   mask_before_vec_a: assert property (@(posedge mclk) disable iff (rst)
      vectorFetch |-> condition_flags[cfm_pkg::FL_I] && $past(!pushStrobe))
      else $error("mask not set before vector");
   half_carry_a: assert property (@(posedge mclk) disable iff (rst)
      (accept && isAdd) |-> ##1 pendFlags[cfm_pkg::FL_H] ==
         ($past(accIn[3:0]) + {1'b0, $past(operand[3:0])} > 5'h0f))
      else $error("half carry wrong");
   zero_neg_a: assert property (@(posedge mclk) disable iff (rst)
      (commit && pendOp[15:8] != cfm_pkg::OP_PREFIX &&
       pendOp[7:0] == 8'hab) |=> condition_flags[cfm_pkg::FL_Z] == (result == 8'h00)
         && condition_flags[cfm_pkg::FL_N] == result[7])
      else $error("zero or negative flag wrong");
   sp_add_a: assert property (@(posedge mclk) disable iff (rst)
      (accept && !isPre && opcode[7:0] == cfm_pkg::OP_SPADD) |-> ##3
         stack_pointer == 16'($past(stack_pointer, 3) +
            {{8{$past(operand[7], 3)}}, $past(operand, 3)})
         && done && condition_flags == $past(condition_flags, 3))
      else $error("stack add wrong");
   wait_mask_a: assert property (@(posedge mclk) disable iff (rst)
      (state == cfm_pkg::ST_WAIT) |-> !condition_flags[cfm_pkg::FL_I] && !coreClockRun)
      else $error("wait mask or clock wrong");
   stab_delay_a: assert property (@(posedge mclk) disable iff (rst)
      $rose(coreClockRun) && $past(state) == cfm_pkg::ST_STAB |->
         $past(stopGap) == 13'(STAB_CYCLES - 1)) else $error("stop restart early");
   break_end_a: assert property (@(posedge mclk) disable iff (rst)
      (commit && breakActive && !breakReq && pendOp[15:8] != cfm_pkg::OP_PREFIX &&
       pendOp[7:0] == OP_RETI) |=> !breakActive) else $error("break not ended");
endmodule

// [cfm_pkg.sv]
// Purpose: constants for the flag and interrupt-mask core
// Assumes: 20 MHz mclk, synchronous active-high reset
// Notes:   register offsets are word indexes on the plain port
package cfm_pkg;
   // flag bit positions
   localparam int FL_V = 7;
   localparam int FL_H = 4;
   localparam int FL_I = 3;
   localparam int FL_N = 2;
   localparam int FL_Z = 1;
   localparam int FL_C = 0;
   localparam logic [7:0] FLAGS_RST   = 8'h68;
   localparam logic [7:0] FLAGS_FIXED = 8'h60;
   localparam logic [15:0] STACK_RST  = 16'h00ff;
   // opcodes
   localparam logic [7:0] OP_PREFIX = 8'h9e;
   localparam logic [7:0] OP_SPADD  = 8'ha7;
   localparam logic [7:0] OP_IXADD  = 8'haf;
   localparam logic [3:0] LO_ADC    = 4'h9;
   localparam logic [3:0] LO_ADD    = 4'hb;
   localparam logic [3:0] LO_AND    = 4'h4;
   localparam logic [3:0] LO_SHL    = 4'h8;
   localparam logic [3:0] LO_SHR    = 4'h7;
   // vectors
   localparam logic [15:0] VEC_BRK     = 16'hfffc;
   localparam logic [15:0] VEC_BRK_MON = 16'hfefc;
   localparam logic [15:0] VEC_IRQ_TOP = 16'hfffa;
   // stacking: pcl, pch, x, a, flags (index high byte never)
   localparam logic [2:0] PUSH_LAST = 3'h4;
   // register port
   localparam logic [1:0] OFS_FLAGS  = 2'h0;
   localparam logic [1:0] OFS_STATUS = 2'h1;
   typedef enum logic [2:0] {
      ST_IDLE, ST_EXEC, ST_PUSH, ST_VECT, ST_WAIT, ST_STOP, ST_STAB
   } cfm_state_e;
endpackage

// [cfm_irq_src.sv]
// Purpose: interrupt and break request sources facing cfm_core
// Assumes: request pulses from the bench, one per source
// Notes:   each request holds until the core acknowledges it
`timescale 1ns/1ps
module cfm_irq_src #(
   parameter int NIRQ = 4
) (
   input  wire logic            mclk,
   input  wire logic            rst,
   input  wire logic [NIRQ-1:0] want,
   input  wire logic            wantBreak,
   input  wire logic [NIRQ-1:0] irqAck,
   input  wire logic            breakActive,
   output logic      [NIRQ-1:0] irqReq,
   output logic                 breakReq
);
   // ********
   // request levels
   // ********
   always_ff @(posedge mclk) begin
      if (rst) begin
         irqReq   <= '0;
         breakReq <= 1'b0;
      end else begin
         irqReq   <= (irqReq | want) & ~irqAck;
         breakReq <= (breakReq | wantBreak) & ~breakActive;
      end
   end
endmodule

// [tb_cfm_core.sv]
// Purpose: self-checking bench for cfm_core
// Assumes: 20 MHz mclk, short stabilisation count
// Notes:   expected flags come from a bench model of the alu
`timescale 1ns/1ps
module tb_cfm_core;
   logic        mclk, rst, execStart, monitorMode, regWr, regRd, wantBreak, breakReq;
   logic        ready, done, pushStrobe, vectorFetch, coreClockRun, breakActive;
   logic [1:0]  regAddr;
   logic [2:0]  pushSel;
   logic [3:0]  irqReq, irqAck, want, lo;
   logic [7:0]  operand, accIn, regWrData, regRdData, result, flags, instrReg, expF;
   logic [15:0] opcode, spOut, indexReg, vectorAddr, rnd, ex;
   int          n_errors, n_tests, cycles, pushCnt, vfCnt, lat;
   logic [3:0]  ops [5];
   logic [15:0] corner [3];

   cfm_core #(.NIRQ(4), .STAB_CYCLES(8)) cfm_core_inst (
      .mclk(mclk), .rst(rst), .execStart(execStart), .opcode(opcode), .operand(operand),
      .accIn(accIn), .irqReq(irqReq), .breakReq(breakReq), .monitorMode(monitorMode),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .ready(ready), .done(done), .result(result),
      .condition_flags(flags), .stack_pointer(spOut), .indexReg(indexReg),
      .pushStrobe(pushStrobe), .pushSel(pushSel), .vectorFetch(vectorFetch),
      .vectorAddr(vectorAddr), .irqAck(irqAck), .instrReg(instrReg),
      .coreClockRun(coreClockRun), .breakActive(breakActive));
   cfm_irq_src #(.NIRQ(4)) cfm_irq_src_inst (
      .mclk(mclk), .rst(rst), .want(want), .wantBreak(wantBreak), .irqAck(irqAck),
      .breakActive(breakActive), .irqReq(irqReq), .breakReq(breakReq));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   // ********
   // monitors and tasks
   // ********
   always @(posedge mclk) begin
      cycles++;
      if (pushStrobe === 1'b1 && pushSel === pushCnt[2:0]) pushCnt++;
      if (vectorFetch === 1'b1) vfCnt++;
      if (cycles == 8000) begin
         n_errors++;
         complete_run();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic exec(input logic [15:0] op, input logic [7:0] opr, input logic [7:0] acc);
      int k;
      k = 0;
      while (ready !== 1'b1 && k < 60) begin
         @(negedge mclk);
         k++;
      end
      @(posedge mclk);
      execStart <= 1'b1;
      opcode    <= op;
      operand   <= opr;
      accIn     <= acc;
      @(posedge mclk);
      execStart <= 1'b0;
      lat = 0;
      do begin
         @(negedge mclk);
         lat++;
      end while (done !== 1'b1 && lat < 60);
   endtask
   task automatic waitVector(input logic [15:0] addr, input logic [3:0] ack);
      pushCnt = 0;
      lat = 0;
      while (vectorFetch !== 1'b1 && lat < 100) begin
         @(negedge mclk);
         lat++;
      end
      check(vectorAddr, addr);
      check(16'(irqAck), 16'(ack));
      check(16'(pushCnt), 16'h5);
      check(16'(flags[3]), 16'h1);
   endtask
   task automatic regAccess(input logic wr, input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      regWr     <= wr;
      regRd     <= ~wr;
      regAddr   <= a;
      regWrData <= d;
      @(posedge mclk);
      regWr <= 1'b0;
      regRd <= 1'b0;
      @(negedge mclk);
   endtask
   task automatic raise(input logic [3:0] bits, input logic brk, input logic mon);
      @(posedge mclk);
      want        <= bits;
      wantBreak   <= brk;
      monitorMode <= mon;
      @(posedge mclk);
      want      <= 4'h0;
      wantBreak <= 1'b0;
      @(negedge mclk);
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] aluExp(input logic [3:0] op, input logic [7:0] a,
                                          input logic [7:0] m, input logic [7:0] f);
      logic [8:0] s;
      logic [7:0] r;
      logic       h, v, c, ci;
      ci = (op == cfm_pkg::LO_ADC) ? f[0] : 1'b0;
      s = {1'b0, a} + {1'b0, m} + {8'h00, ci};
      h = f[4];
      c = f[0];
      v = 1'b0;
      r = a & m;
      if (op == cfm_pkg::LO_SHL) begin
         r = {m[6:0], 1'b0};
         c = m[7];
         v = r[7] ^ c;
      end else if (op == cfm_pkg::LO_SHR) begin
         r = {m[7], m[7:1]};
         c = m[0];
         v = r[7] ^ c;
      end else if (op != cfm_pkg::LO_AND) begin
         r = s[7:0];
         c = s[8];
         h = ({1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, ci}) > 5'h0f;
         v = (a[7] == m[7]) && (r[7] != a[7]);
      end
      return {r, v, 2'b11, h, f[3], r[7], r == 8'h00, c};
   endfunction
   task automatic complete_run();
      if (n_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ********
   // main sequence
   // ********
   initial begin
      {rst, execStart, monitorMode, regWr, regRd, wantBreak} = 6'b100000;
      {regAddr, want, operand, accIn, regWrData, opcode} = '0;
      {n_errors, n_tests, cycles, pushCnt, vfCnt} = '0;
      rnd = 16'h0035;
      ops = '{cfm_pkg::LO_ADD, cfm_pkg::LO_ADC, cfm_pkg::LO_AND, cfm_pkg::LO_SHL,
              cfm_pkg::LO_SHR};
      corner = '{16'h0f01, 16'h8080, 16'h7f01};
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check(16'(flags), 16'h0068);
      check(spOut, 16'h00ff);
      raise(4'b0110, 1'b0, 1'b0);
      repeat (12) @(negedge mclk);
      check(16'(vfCnt), 16'h0);
      exec(16'h009a, 8'h00, 8'h00);
      check(16'(flags), 16'h0060);
      waitVector(16'hfff6, 4'b0010);
      exec(16'h0080, 8'h00, 8'h00);
      check(16'(flags), 16'h0060);
      waitVector(16'hfff4, 4'b0100);
      regAccess(1'b1, 2'h0, 8'h00);
      regAccess(1'b0, 2'h0, 8'h00);
      check(16'(regRdData), 16'h0068);
      regAccess(1'b0, 2'h3, 8'h00);
      check(16'(regRdData), 16'h0000);
      expF = 8'h68;
      exec(16'h00a7, 8'hff, 8'h00);
      check(spOut, 16'h00fe);
      check(16'(lat), 16'h3);
      exec(16'h00af, 8'h80, 8'h00);
      check(indexReg, 16'hff80);
      check(16'(flags), 16'(expF));
      for (int i = 0; i < 60; i++) begin
         rnd = lfsr(rnd);
         ex = (i < 3) ? corner[i] : rnd;
         lo = ops[i % 5];
         exec({8'h00, (lo == cfm_pkg::LO_SHL || lo == cfm_pkg::LO_SHR) ? 4'h4 : 4'ha, lo},
              ex[7:0], ex[15:8]);
         check(16'(lat), (lo == cfm_pkg::LO_SHL || lo == cfm_pkg::LO_SHR) ? 16'h2 : 16'h3);
         ex = aluExp(lo, ex[15:8], ex[7:0], expF);
         expF = ex[7:0];
         check(16'(result), 16'(ex[15:8]));
         check(16'(flags), 16'(expF));
      end
      for (int mon = 1; mon >= 0; mon--) begin
         raise(4'h0, 1'b1, mon[0]);
         waitVector(mon[0] ? 16'hfefc : 16'hfffc, 4'h0);
         check(16'(instrReg), 16'h0083);
         exec(16'h0080, 8'h08, 8'h00);
         check(16'(breakActive), 16'h0);
      end
      exec(16'h0072, 8'h00, 8'h9a);
      check(16'(result), 16'h0000);
      check(16'(flags), 16'h006b);
      for (int w = 0; w < 2; w++) begin
         exec(w ? 16'h008e : 16'h008f, 8'h00, 8'h00);
         @(negedge mclk);
         check(16'(coreClockRun), 16'h0);
         check(16'(flags[3]), 16'h0);
         raise(4'b0001, 1'b0, 1'b0);
         waitVector(16'hfff8, 4'b0001);
         check(16'(lat > w * 8), 16'h1);
      end
      complete_run();
   end
endmodule
